//--- core/dig_top.sv
`timescale 1ns/1ps
`include "dig_cfg.svh"
module dig_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hires_mode_i,
  input wire logic [`DIG_X_W-1:0] scanline_len_i,
  input wire logic [`DIG_PTR_W-1:0] entry_ptr_i,
  input wire logic visible_line_channel_n_i,
  input wire logic end_of_field_channel_n_i,
  input wire logic fetch_valid_i,
  input wire logic [`DIG_PTR_W-1:0] fetch_data_i,
  output logic fe_enable_o,
  output logic space_avail_o,
  output logic fetch_req_o,
  output logic [`DIG_PTR_W-1:0] fetch_addr_o,
  output logic [`DIG_CODE_W-1:0] did_even_o,
  output logic [`DIG_CODE_W-1:0] did_odd_o,
  output logic underflow_o
);
  // single clock; the front end advances only on fe_en_r
  logic fe_en_r; // [R16]
  logic fe_en_nxt;
  logic eof_prev_r;
  logic eof_prev_nxt;
  logic flush;
  logic visible;

  always_comb begin
    fe_en_nxt = hires_mode_i ? ~fe_en_r : 1'b1; // [R17]
    eof_prev_nxt = end_of_field_channel_n_i;
    flush = eof_prev_r && !end_of_field_channel_n_i; // [R19]
    visible = !visible_line_channel_n_i; // [R18]
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fe_en_r <= 1'b1;
      eof_prev_r <= 1'b1;
    end else begin
      fe_en_r <= fe_en_nxt;
      eof_prev_r <= eof_prev_nxt;
    end
  end

  assign fe_enable_o = fe_en_r;

  // front end: frame table walk and record fetch
  dig_pkg::dig_fe_state_type state_r;
  dig_pkg::dig_fe_state_type state_nxt;
  logic [`DIG_PTR_W-1:0] frame_ptr_r;
  logic [`DIG_PTR_W-1:0] frame_ptr_nxt;
  logic [`DIG_PTR_W-1:0] addr_r;
  logic [`DIG_PTR_W-1:0] addr_nxt;
  dig_pkg::dig_rec_type prev_r;
  dig_pkg::dig_rec_type prev_nxt;
  dig_pkg::dig_rec_type rec;
  dig_pkg::dig_entry_type push_entry;
  logic [`DIG_X_W-1:0] dur;
  logic stop;
  logic take;
  logic push;
  logic fetching;
  logic space;
  logic empty;
  logic [`DIG_AW:0] level;
  dig_pkg::dig_entry_type head;
  logic pop;

  assign rec = dig_pkg::dig_rec_type'(fetch_data_i); // [R3]

  dig_conv u_conv (
    .prev_x_i(prev_r.x),
    .x_i(rec.x),
    .len_i(scanline_len_i),
    .dur_o(dur),
    .stop_o(stop)
  );

  always_comb begin
    fetching = (state_r == dig_pkg::FE_FRAME) ||
               (state_r == dig_pkg::FE_FIRST) ||
               (state_r == dig_pkg::FE_REC);
    take = fe_en_r && fetch_valid_i && fetching;
    push = take && (state_r == dig_pkg::FE_REC) && (dur != `DIG_ZERO_DUR);
    push_entry.code_even = prev_r.code;
    push_entry.code_odd = prev_r.code;
    push_entry.dur = dur; // [R10]
    state_nxt = state_r;
    frame_ptr_nxt = frame_ptr_r;
    addr_nxt = addr_r;
    prev_nxt = prev_r;
    if (flush) begin
      // restart from the table base: tolerates mid-frame table edits
      state_nxt = dig_pkg::FE_FRAME; // [R9]
      frame_ptr_nxt = entry_ptr_i; // [R8]
      addr_nxt = entry_ptr_i;
    end else if (take) begin
      case (state_r)
        dig_pkg::FE_FRAME: begin
          if (fetch_data_i == `DIG_END_FRAME) begin
            state_nxt = dig_pkg::FE_DONE; // [R2]
          end else begin
            state_nxt = dig_pkg::FE_FIRST;
            addr_nxt = fetch_data_i; // [R1] [R6]
            frame_ptr_nxt = frame_ptr_r + 1'b1;
          end
        end
        dig_pkg::FE_FIRST: begin
          // first position is taken as the line start
          prev_nxt = rec; // [R4]
          if (rec.x == `DIG_END_LINE) begin
            state_nxt = dig_pkg::FE_FRAME; // [R5]
            addr_nxt = frame_ptr_r;
          end else begin
            state_nxt = dig_pkg::FE_REC;
            addr_nxt = addr_r + 1'b1;
          end
        end
        dig_pkg::FE_REC: begin
          if (stop) begin
            state_nxt = dig_pkg::FE_FRAME; // [R7]
            addr_nxt = frame_ptr_r;
          end else begin
            prev_nxt = rec;
            addr_nxt = addr_r + 1'b1;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= dig_pkg::FE_WAIT;
      frame_ptr_r <= '0;
      addr_r <= '0;
      prev_r <= '0;
    end else begin
      state_r <= state_nxt;
      frame_ptr_r <= frame_ptr_nxt;
      addr_r <= addr_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign space_avail_o = space; // [R12]
  assign fetch_req_o = space && fetching; // [R12]
  assign fetch_addr_o = addr_r;

  dig_fifo u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .push_i(push),
    .wdata_i(push_entry),
    .pop_i(pop),
    .rdata_o(head),
    .empty_o(empty),
    .space_o(space),
    .level_o(level)
  );

  // back end: run-length expansion during visible lines
  logic [`DIG_X_W-1:0] remain_r;
  logic [`DIG_X_W-1:0] remain_nxt;
  logic [`DIG_CODE_W-1:0] even_nxt;
  logic [`DIG_CODE_W-1:0] odd_nxt;
  logic err_r;
  logic err_nxt;
  logic need;

  always_comb begin
    need = visible && (remain_r <= `DIG_ONE_DUR);
    pop = need && !empty && !err_r && !flush; // [R14]
    remain_nxt = remain_r;
    even_nxt = did_even_o;
    odd_nxt = did_odd_o;
    err_nxt = err_r;
    if (flush) begin
      err_nxt = 1'b0; // [R15]
      remain_nxt = `DIG_ZERO_DUR;
      even_nxt = `DIG_ZERO_CODE;
      odd_nxt = `DIG_ZERO_CODE;
    end else if (!visible || err_r) begin
      remain_nxt = `DIG_ZERO_DUR; // [R18]
      even_nxt = `DIG_ZERO_CODE;
      odd_nxt = `DIG_ZERO_CODE;
    end else if (pop) begin
      remain_nxt = head.dur; // [R14]
      even_nxt = head.code_even;
      odd_nxt = head.code_odd;
    end else if (need) begin
      // empty read: blank until the next retrace flush
      err_nxt = 1'b1; // [R15]
      remain_nxt = `DIG_ZERO_DUR;
      even_nxt = `DIG_ZERO_CODE;
      odd_nxt = `DIG_ZERO_CODE;
    end else begin
      remain_nxt = remain_r - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      remain_r <= '0;
      did_even_o <= '0;
      did_odd_o <= '0;
      err_r <= 1'b0;
    end else begin
      remain_r <= remain_nxt;
      did_even_o <= even_nxt;
      did_odd_o <= odd_nxt;
      err_r <= err_nxt;
    end
  end

  assign underflow_o = err_r;

  property p_lowres_enable;
    @(posedge clock_i) disable iff (rst_i)
    !hires_mode_i |=> fe_enable_o;
  endproperty
  a_lowres_enable: assert property (p_lowres_enable) // [R17]
    else $error("front-end enable dropped in low-res mode");

  property p_hires_alternate;
    @(posedge clock_i) disable iff (rst_i)
    hires_mode_i && fe_enable_o |=> !fe_enable_o;
  endproperty
  a_hires_alternate: assert property (p_hires_alternate) // [R17]
    else $error("front-end enable not halved in high-res mode");

  property p_space_limit;
    @(posedge clock_i) disable iff (rst_i)
    level >= `DIG_SPACE_LIMIT |-> !space_avail_o && !fetch_req_o;
  endproperty
  a_space_limit: assert property (p_space_limit) // [R13]
    else $error("space flag still up at fill limit");

  property p_frame_end;
    @(posedge clock_i) disable iff (rst_i)
    take && !flush && state_r == dig_pkg::FE_FRAME &&
      fetch_data_i == `DIG_END_FRAME
      |=> state_r == dig_pkg::FE_DONE && !fetch_req_o;
  endproperty
  a_frame_end: assert property (p_frame_end) // [R2]
    else $error("frame terminator not honoured");

  property p_line_ptr;
    @(posedge clock_i) disable iff (rst_i)
    take && !flush && state_r == dig_pkg::FE_FRAME &&
      fetch_data_i != `DIG_END_FRAME
      |=> state_r == dig_pkg::FE_FIRST &&
          fetch_addr_o == $past(fetch_data_i);
  endproperty
  a_line_ptr: assert property (p_line_ptr) // [R1]
    else $error("line not fetched through its frame pointer");

  property p_line_stop;
    @(posedge clock_i) disable iff (rst_i)
    take && !flush && state_r == dig_pkg::FE_REC && stop
      |=> state_r == dig_pkg::FE_FRAME &&
          fetch_addr_o == $past(frame_ptr_r);
  endproperty
  a_line_stop: assert property (p_line_stop) // [R7]
    else $error("record fetch continued past line end");

  property p_flush;
    @(posedge clock_i) disable iff (rst_i)
    flush |=> level == 7'h0000 && !underflow_o &&
              state_r == dig_pkg::FE_FRAME && fetch_addr_o == $past(entry_ptr_i);
  endproperty
  a_flush: assert property (p_flush) // [R9]
    else $error("field end did not flush and restart");

  property p_blank;
    @(posedge clock_i) disable iff (rst_i)
    !visible |=> did_even_o == `DIG_ZERO_CODE && did_odd_o == `DIG_ZERO_CODE;
  endproperty
  a_blank: assert property (p_blank) // [R18]
    else $error("codes driven outside visible line");

  property p_hold;
    @(posedge clock_i) disable iff (rst_i)
    visible && !flush && !err_r && remain_r > `DIG_ONE_DUR
      |=> $stable(did_even_o) && $stable(did_odd_o) &&
          remain_r == $past(remain_r) - 1'b1;
  endproperty
  a_hold: assert property (p_hold) // [R14]
    else $error("code pair not held for its duration");

  property p_load;
    @(posedge clock_i) disable iff (rst_i)
    pop |=> did_even_o == $past(head.code_even) &&
            remain_r == $past(head.dur);
  endproperty
  a_load: assert property (p_load) // [R14]
    else $error("popped entry not presented");

  property p_underflow;
    @(posedge clock_i) disable iff (rst_i)
    need && empty && !flush |=> underflow_o ##1 (underflow_o || $past(flush));
  endproperty
  a_underflow: assert property (p_underflow) // [R15]
    else $error("empty read not caught");

  property p_push_count;
    @(posedge clock_i) disable iff (rst_i)
    push && !pop && !flush && level < 7'h0040 |=> level == $past(level) + 1'b1;
  endproperty
  a_push_count: assert property (p_push_count) // [R11]
    else $error("converted segment not stored");
endmodule : dig_top

//--- core/dig_cfg.svh
`ifndef DIG_CFG_SVH
`define DIG_CFG_SVH
// What this block does
// [R1] frame entry points to line's first record
// [R2] all-ones frame entry ends the frame
// [R3] record holds 5-bit code, 11-bit position
// [R4] table builder starts each line at zero
// [R5] all-ones position ends the line
// [R6] lines reached only through frame pointers
// [R7] stop at scanline length or end record
// [R8] only length and entry pointer change resolution
// [R9] field end flushes corrupt codes from buffer
// [R10] buffer is 64 entries of 21 bits
// [R11] converter turns positions into cycle counts
// [R12] space flag requests next record fetch
// [R13] space flag drops at 58 entries
// [R14] visible lines pop entries, show two codes
// [R15] empty read tolerated, recovers after retrace
// [R16] everything runs on one half-pixel clock
// [R17] front-end enable halves rate, lowres always on
// [R18] visible-line channel gates code generation
// [R19] end-of-field channel triggers buffer flush
// [R20] duration is position difference, truncated at length
`define DIG_CODE_W 5
`define DIG_X_W 11
`define DIG_PTR_W 16
`define DIG_DEPTH 64
`define DIG_AW 6
`define DIG_SPACE_LIMIT 7'h003A
`define DIG_END_FRAME 16'hFFFF
`define DIG_END_LINE 11'h07FF
`define DIG_ZERO_DUR 11'h0000
`define DIG_ONE_DUR 11'h0001
`define DIG_ZERO_CODE 5'h00
`endif

//--- core/dig_pkg.sv
`include "dig_cfg.svh"
package dig_pkg;
  typedef struct packed {
    logic [`DIG_CODE_W-1:0] code;
    logic [`DIG_X_W-1:0] x;
  } dig_rec_type;

  typedef struct packed {
    logic [`DIG_CODE_W-1:0] code_even;
    logic [`DIG_CODE_W-1:0] code_odd;
    logic [`DIG_X_W-1:0] dur;
  } dig_entry_type;

  typedef enum logic [2:0] {
    FE_WAIT = 3'b000,
    FE_FRAME = 3'b001,
    FE_FIRST = 3'b010,
    FE_REC = 3'b011,
    FE_DONE = 3'b100
  } dig_fe_state_type;
endpackage : dig_pkg

//--- core/dig_conv.sv
`timescale 1ns/1ps
`include "dig_cfg.svh"
module dig_conv (
  input wire logic [`DIG_X_W-1:0] prev_x_i,
  input wire logic [`DIG_X_W-1:0] x_i,
  input wire logic [`DIG_X_W-1:0] len_i,
  output logic [`DIG_X_W-1:0] dur_o,
  output logic stop_o
);
  logic [`DIG_X_W-1:0] end_x;

  always_comb begin
    stop_o = (x_i == `DIG_END_LINE) || (x_i >= len_i); // [R5] [R7]
    end_x = (x_i >= len_i) ? len_i : x_i; // [R20]
    // positions round down to a two-pixel boundary
    if (end_x > prev_x_i) begin
      dur_o = (end_x >> 1) - (prev_x_i >> 1); // [R11] [R20]
    end else begin
      dur_o = `DIG_ZERO_DUR;
    end
  end
endmodule : dig_conv

//--- core/dig_fifo.sv
`timescale 1ns/1ps
`include "dig_cfg.svh"
module dig_fifo (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire dig_pkg::dig_entry_type wdata_i,
  input wire logic pop_i,
  output dig_pkg::dig_entry_type rdata_o,
  output logic empty_o,
  output logic space_o,
  output logic [`DIG_AW:0] level_o
);
  dig_pkg::dig_entry_type mem_r [0:`DIG_DEPTH-1]; // [R10]
  logic [`DIG_AW-1:0] wptr_r;
  logic [`DIG_AW-1:0] wptr_nxt;
  logic [`DIG_AW-1:0] rptr_r;
  logic [`DIG_AW-1:0] rptr_nxt;
  logic [`DIG_AW:0] cnt_r;
  logic [`DIG_AW:0] cnt_nxt;
  logic do_push;
  logic do_pop;

  always_comb begin
    do_push = push_i && (cnt_r != 7'(`DIG_DEPTH));
    do_pop = pop_i && (cnt_r != 7'h0000);
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt = cnt_r;
    if (flush_i) begin
      wptr_nxt = '0; // [R9]
      rptr_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (do_push) begin
        wptr_nxt = wptr_r + 1'b1;
      end
      if (do_pop) begin
        rptr_nxt = rptr_r + 1'b1;
      end
      cnt_nxt = cnt_r + 7'(do_push) - 7'(do_pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_push && !flush_i) begin
      mem_r[wptr_r] <= wdata_i;
    end
  end

  assign rdata_o = mem_r[rptr_r];
  assign empty_o = (cnt_r == 7'h0000);
  assign level_o = cnt_r;
  // headroom covers fetches already in the controller pipeline
  assign space_o = (cnt_r < `DIG_SPACE_LIMIT); // [R13]
endmodule : dig_fifo

//--- test/dig_mem_model.sv
`timescale 1ns/1ps
`include "dig_cfg.svh"
module dig_mem_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic fetch_req_i,
  input wire logic [`DIG_PTR_W-1:0] fetch_addr_i,
  output logic fetch_valid_o,
  output logic [`DIG_PTR_W-1:0] fetch_data_o
);
  logic [`DIG_PTR_W-1:0] mem [0:255];
  logic [`DIG_PTR_W-1:0] word;
  initial fetch_valid_o = 1'b0;
  // answer only while the space flag asks; stalls model a slow controller
  always @(posedge clock_i) begin
    #2;
    fetch_valid_o = !rst_i && fetch_req_i && !stall_i;
  end
  assign word = mem[fetch_addr_i[7:0]];
  // idle bus shows the inverse so stale data cannot pass for a read
  assign fetch_data_o = fetch_valid_o ? word : ~word;
endmodule : dig_mem_model

//--- test/dig_top_tb.sv
`timescale 1ns/1ps
`include "dig_cfg.svh"
module dig_top_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hires = 1'b0;
  logic vis_n = 1'b1;
  logic eof_n = 1'b1;
  logic stall = 1'b0;
  logic rand_on = 1'b0;
  logic [10:0] len = 11'h280;
  logic [15:0] eptr = 16'h0010;
  logic fe_en, space, req, valid, uflow, prev_en;
  logic [15:0] addr, data;
  logic [4:0] de, dd;
  int errors = 0;
  int total_checks = 0;
  int seed = 94265;
  int taken = 0;
  int exp_q[$];
  logic [15:0] got_q[$];

  dig_top dut (.clock_i(clock_i), .rst_i(rst_i), .hires_mode_i(hires),
    .scanline_len_i(len), .entry_ptr_i(eptr),
    .visible_line_channel_n_i(vis_n), .end_of_field_channel_n_i(eof_n),
    .fetch_valid_i(valid), .fetch_data_i(data), .fe_enable_o(fe_en),
    .space_avail_o(space), .fetch_req_o(req), .fetch_addr_o(addr),
    .did_even_o(de), .did_odd_o(dd), .underflow_o(uflow));
  dig_mem_model mem (.clock_i(clock_i), .rst_i(rst_i), .stall_i(stall),
    .fetch_req_i(req), .fetch_addr_i(addr), .fetch_valid_o(valid),
    .fetch_data_o(data));

  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (valid && fe_en && req) taken++;
    #1;
    stall = rand_on & ($random(seed) % 2 != 0);
  end

  task results;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task seg(input int c, input int d);
    repeat (d) exp_q.push_back(c);
  endtask : seg
  task flush;
    eof_n = 1'b0;
    cyc(1);
    eof_n = 1'b1;
    cyc(1);
  endtask : flush
  // wait until the walker stops asking for words
  task fill;
    int i;
    int k;
    i = 0;
    k = 0;
    cyc(4);
    while (k < 3 && i < 2000) begin
      k = (req === 1'b0) ? k + 1 : 0;
      cyc(1);
      i++;
    end
    if (i == 2000) begin
      errors++;
      results();
    end
  endtask : fill
  task show(input int n);
    int i;
    got_q.delete();
    vis_n = 1'b0;
    for (i = 0; i < n + 3; i++) begin
      if (i == n) vis_n = 1'b1;
      cyc(1);
      if (de !== 5'h00) got_q.push_back({11'h000, de});
      chk("odd code", {11'h000, de}, {11'h000, dd});
    end
    chk("code count", exp_q.size(), got_q.size());
    foreach (exp_q[j]) if (j < got_q.size()) chk("code", exp_q[j], got_q[j]);
    chk("idle code", 16'h0000, {11'h000, de});
    exp_q.delete();
  endtask : show

  initial begin
    int i;
    mem.mem[16'h10] = 16'h0040;
    mem.mem[16'h11] = 16'h0080;
    mem.mem[16'h12] = 16'h0040;
    mem.mem[16'h13] = 16'hFFFF;
    mem.mem[16'h20] = 16'h0080;
    mem.mem[16'h21] = 16'h0080;
    mem.mem[16'h22] = 16'hFFFF;
    mem.mem[16'h30] = 16'h00E0;
    mem.mem[16'h31] = 16'h0090;
    mem.mem[16'h32] = 16'hFFFF;
    mem.mem[16'hE0] = {5'h00, 11'h7FF};
    mem.mem[16'h40] = {5'h03, 11'h000};
    mem.mem[16'h41] = {5'h05, 11'h064};
    mem.mem[16'h42] = {5'h07, 11'h7FF};
    mem.mem[16'h80] = {5'h09, 11'h000};
    mem.mem[16'h81] = {5'h02, 11'h12C};
    mem.mem[16'h82] = {5'h06, 11'h2BC};
    mem.mem[16'h83] = {5'h04, 11'h7FF};
    for (i = 0; i < 70; i++) mem.mem[16'h90 + i] = {5'h01, 11'(2 * i)};
    repeat (4) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk("reset req", 16'h0000, {15'h0000, req});
    chk("reset space", 16'h0001, {15'h0000, space});
    chk("reset code", 16'h0000, {11'h000, de});
    flush();
    fill();
    for (i = 0; i < 4; i++) begin
      chk("lowres enable", 16'h0001, {15'h0000, fe_en});
      cyc(1);
    end
    seg(3, 50);
    seg(5, 270);
    seg(9, 150);
    seg(2, 170);
    show(640);
    vis_n = 1'b0;
    cyc(330);
    chk("underflow", 16'h0001, {15'h0000, uflow});
    chk("code after empty", 16'h0000, {11'h000, de});
    vis_n = 1'b1;
    len = 11'h190;
    eptr = 16'h0020;
    hires = 1'b1;
    rand_on = 1'b1;
    flush();
    chk("flushed error", 16'h0000, {15'h0000, uflow});
    for (i = 0; i < 4; i++) begin
      prev_en = fe_en;
      @(posedge clock_i);
      #1;
      chk("hires enable", {15'h0000, ~prev_en}, {15'h0000, fe_en});
    end
    fill();
    seg(9, 150);
    seg(2, 50);
    show(200);
    hires = 1'b0;
    rand_on = 1'b0;
    len = 11'h7FE;
    eptr = 16'h0030;
    // clear before the flush: the frame word is taken on the next edge
    taken = 0;
    flush();
    fill();
    chk("space full", 16'h0000, {15'h0000, space});
    chk("fill words", 16'h0001, {15'h0000, taken inside {62, 63}});
    flush();
    chk("space empty", 16'h0001, {15'h0000, space});
    results();
  end
endmodule : dig_top_tb
